//--- rtl/dcr_pkg.sv
// Purpose: Constants for the device control register block.
// Assumes: One 40 MHz clock domain.
// Notes:   Field positions and reset values are named once here.
package dcr_pkg;
  localparam int unsigned DATA_W            = 16;
  localparam int unsigned PORT_N            = 20;
  localparam int unsigned PORT_W            = 5;
  localparam int unsigned ADDR_W            = 8;
  localparam int unsigned PRESET_W          = 12;
  localparam int unsigned TEMP_W            = 12;
  localparam int unsigned ADC_MODE_LSB      = 0;
  localparam int unsigned DAC_MODE_LSB      = 2;
  localparam int unsigned RATE_LSB          = 4;
  localparam int unsigned DAC_REF_BIT       = 6;
  localparam int unsigned THERM_SHDN_BIT    = 7;
  localparam int unsigned TEMP_EN_LSB       = 8;
  localparam int unsigned TEMP_PER_BIT      = 11;
  localparam int unsigned SERIES_RES_CANCEL_EN_BIT     = 12;
  localparam int unsigned LOW_POWER_BIT     = 13;
  localparam int unsigned BURST_BIT         = 14;
  localparam int unsigned SOFT_RESET_BIT    = 15;
  localparam logic [15:0] CTRL_RESET        = 16'h0000;
  localparam logic [11:0] PRESET_RESET      = 12'h000;
  // 145 C at 0.125 C per LSB, two's complement
  localparam logic [11:0] SHDN_LIMIT        = 12'h488;
  localparam int unsigned CLK_MHZ           = 40;
  localparam int unsigned PULSE_NS          = 100;
  localparam int unsigned PULSE_CYC         = (PULSE_NS * CLK_MHZ) / 1000;
  localparam int unsigned IMM_GAP_US        = 80;
  localparam int unsigned IMM_GAP_CYC       = IMM_GAP_US * CLK_MHZ;
  localparam int unsigned POR_CYC           = 16;
  typedef enum logic [1:0] {ADC_IDLE, ADC_SINGLE_SWEEP, ADC_SINGLE_CONV, ADC_CONT}
    dcr_adc_mode_e;
  typedef enum logic [1:0] {DAC_SEQ, DAC_IMMEDIATE, DAC_PRESET1, DAC_PRESET2}
    dcr_dac_mode_e;
endpackage : dcr_pkg

//--- rtl/dcr_device_control.sv
// Purpose: Device control register and the sequencing logic it steers.
// Assumes: Serial interface decodes writes into ctrl_wr/preset_wr strobes.
// Notes:   Overview of operation follows.
// Overview of operation
// - ADC mode 00 starts no conversions
// - Mode 01 trigger runs one full sweep
// - Sweep runs lowest to highest ADC port
// - Mode 10 converts next port per trigger
// - Mode 11 sweeps forever, ignores trigger
// - DAC mode 00 refreshes ports sequentially
// - Mode 01 updates written port, continues onward
// - Modes 10/11 drive preset one/two
// - Bits 5:4 select conversion rate
// - Bit 6 selects DAC reference source
// - Hot internal reading resets whole device
// - Bits 10:8 enable three temperature monitors
// - Bit 11 selects extended temperature conversion
// - Bit 12 enables series resistance cancellation
// - Bit 13 low power, ports high-impedance
// - Clearing low power reruns power-on sequence
// - Burst step plus one when bit14 clear
// - Bit14 set steps to next configured port
// - Contextual steps only ADC reads, DAC writes
// - Writing bit 15 soft resets, self clears
// - Continuous sweep end pulses interrupt 100ns
// - Presets 12-bit, leave DAC data untouched
`timescale 1ns/1ps
module dcr_device_control
  import dcr_pkg::*;
#(
  parameter int unsigned IMM_GAP = dcr_pkg::IMM_GAP_CYC
) (
  input  wire logic                        clk,
  input  wire logic                        rst_b,
  input  wire logic                        ctrl_wr,
  input  wire logic [dcr_pkg::DATA_W-1:0]  ctrl_wdata,
  output logic      [dcr_pkg::DATA_W-1:0]  ctrl_rdata,
  input  wire logic                        preset1_wr,
  input  wire logic                        preset2_wr,
  input  wire logic [dcr_pkg::PRESET_W-1:0] preset_wdata,
  output logic      [dcr_pkg::PRESET_W-1:0] preset1_rdata,
  output logic      [dcr_pkg::PRESET_W-1:0] preset2_rdata,
  input  wire logic [dcr_pkg::PORT_N-1:0]  adc_port_map,
  input  wire logic [dcr_pkg::PORT_N-1:0]  dac_port_map,
  input  wire logic                        convert_trigger,
  input  wire logic                        adc_conv_done,
  output logic                             adc_start,
  output logic      [dcr_pkg::PORT_W-1:0]  adc_port,
  output logic      [1:0]                  adc_rate_select,
  output logic                             adc_sweep_done,
  output logic                             sweep_int_pulse,
  input  wire logic                        dac_data_wr,
  input  wire logic [dcr_pkg::PORT_W-1:0]  dac_data_port,
  input  wire logic                        dac_update_done,
  output logic                             dac_update_start,
  output logic      [dcr_pkg::PORT_W-1:0]  dac_port,
  output logic                             dac_use_preset,
  output logic      [dcr_pkg::PRESET_W-1:0] dac_preset_value,
  output logic                             dac_ref_select,
  output logic      [2:0]                  temp_monitor_enables,
  output logic                             temp_conv_time_select,
  output logic                             series_res_cancel_en,
  input  wire logic                        temp_int_valid,
  input  wire logic [dcr_pkg::TEMP_W-1:0]  temp_int_value,
  output logic                             low_power_en,
  output logic                             ports_hiz,
  output logic                             por_busy,
  output logic                             device_reset,
  input  wire logic                        burst_step,
  input  wire logic                        burst_is_read,
  input  wire logic                        burst_adc_data,
  input  wire logic                        burst_dac_data,
  input  wire logic [dcr_pkg::PORT_W-1:0]  burst_port,
  output logic      [dcr_pkg::PORT_W-1:0]  burst_next_port,
  output logic                             burst_next_valid
);
  import dcr_pkg::*;

  if (IMM_GAP < 1) begin : g_gap_chk
    $error("IMM_GAP must be at least one cycle");
  end
  if (PULSE_CYC > 7 || POR_CYC > 31) begin : g_cnt_chk
    $error("Pulse or power-on count too wide for its counter");
  end

  logic [DATA_W-1:0]   ctrl_q;
  logic [PRESET_W-1:0] preset1_q;
  logic [PRESET_W-1:0] preset2_q;
  logic                soft_rst_q;
  logic                therm_rst;
  logic                int_rst;
  logic [4:0]          por_cnt_q;
  logic                adc_busy_q;
  logic                adc_sweeping_q;
  logic [PORT_W-1:0]   adc_port_q;
  logic [PORT_W-1:0]   conv_ptr_q;
  logic                adc_start_q;
  logic [2:0]          pulse_cnt_q;
  logic                adc_done_q;
  logic [PORT_W-1:0]   dac_port_q;
  logic                dac_busy_q;
  logic                dac_start_q;
  logic                imm_pend_q;
  logic [PORT_W-1:0]   imm_port_q;
  logic [31:0]         gap_cnt_q;
  dcr_adc_mode_e       adc_mode;
  dcr_dac_mode_e       dac_mode;
  logic [PORT_W:0]     adc_first;
  logic [PORT_W:0]     adc_from_ptr;
  logic [PORT_W:0]     adc_after;
  logic [PORT_W:0]     dac_first;
  logic [PORT_W:0]     dac_after;
  logic [PORT_W-1:0]   adc_pick;
  logic [PORT_W-1:0]   dac_pick;

  // Next set port at or above a start index; top bit flags a hit
  function automatic logic [PORT_W:0] next_set(input logic [PORT_N-1:0] map,
                                               input logic [PORT_W-1:0] from);
    logic [PORT_W:0] r;
    r = {1'b0, PORT_W'(0)};
    for (int i = PORT_N - 1; i >= 0; i--) begin
      if (map[i] && (i >= int'(from))) r = {1'b1, PORT_W'(i)};
    end
    return r;
  endfunction : next_set

  assign adc_first    = next_set(adc_port_map, '0);
  assign adc_from_ptr = next_set(adc_port_map, conv_ptr_q);
  assign adc_after    = next_set(adc_port_map, adc_port_q + PORT_W'(1));
  assign dac_first    = next_set(dac_port_map, '0);
  assign dac_after    = next_set(dac_port_map, dac_port_q + PORT_W'(1));
  // No hit above the pointer wraps to the lowest configured port
  assign adc_pick = adc_from_ptr[PORT_W] ? adc_from_ptr[PORT_W-1:0] : adc_first[PORT_W-1:0];
  assign dac_pick = dac_after[PORT_W] ? dac_after[PORT_W-1:0] : dac_first[PORT_W-1:0];

  assign adc_mode = dcr_adc_mode_e'(ctrl_q[ADC_MODE_LSB +: 2]);
  assign dac_mode = dcr_dac_mode_e'(ctrl_q[DAC_MODE_LSB +: 2]);

  // Thermal trip behaves as a full device reset
  assign therm_rst = ctrl_q[THERM_SHDN_BIT] && ctrl_q[TEMP_EN_LSB] && temp_int_valid
                     && !temp_int_value[TEMP_W-1] && (temp_int_value > SHDN_LIMIT);
  assign int_rst   = soft_rst_q || therm_rst;
  assign device_reset = int_rst;

  // Soft reset is taken one cycle after the write so the write itself completes
  always_ff @(posedge clk) begin
    if (!rst_b) soft_rst_q <= 1'b0;
    else        soft_rst_q <= ctrl_wr && ctrl_wdata[SOFT_RESET_BIT] && !soft_rst_q;
  end

  always_ff @(posedge clk) begin
    if (!rst_b || int_rst) begin
      ctrl_q <= CTRL_RESET;
    end else if (ctrl_wr) begin
      ctrl_q <= ctrl_wdata & ~(16'h0001 << SOFT_RESET_BIT);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b || int_rst) begin
      preset1_q <= PRESET_RESET;
      preset2_q <= PRESET_RESET;
    end else begin
      if (preset1_wr) preset1_q <= preset_wdata;
      if (preset2_wr) preset2_q <= preset_wdata;
    end
  end

  assign ctrl_rdata    = ctrl_q;
  assign preset1_rdata = preset1_q;
  assign preset2_rdata = preset2_q;

  assign adc_rate_select       = ctrl_q[RATE_LSB +: 2];
  assign dac_ref_select        = ctrl_q[DAC_REF_BIT];
  assign temp_monitor_enables  = ctrl_q[TEMP_EN_LSB +: 3];
  assign temp_conv_time_select = ctrl_q[TEMP_PER_BIT];
  assign series_res_cancel_en  = ctrl_q[SERIES_RES_CANCEL_EN_BIT];
  assign low_power_en          = ctrl_q[LOW_POWER_BIT];

  // Power-on sequence rerun on leaving low power; analog held off meanwhile
  always_ff @(posedge clk) begin
    if (!rst_b || int_rst) begin
      por_cnt_q <= 5'(POR_CYC);
    end else if (ctrl_wr && ctrl_q[LOW_POWER_BIT] && !ctrl_wdata[LOW_POWER_BIT]) begin
      por_cnt_q <= 5'(POR_CYC);
    end else if (por_cnt_q != 5'h00) begin
      por_cnt_q <= por_cnt_q - 5'h01;
    end
  end
  assign por_busy  = (por_cnt_q != 5'h00);
  assign ports_hiz = low_power_en || por_busy;

  // ADC sequencer
  always_ff @(posedge clk) begin
    if (!rst_b || int_rst) begin
      adc_busy_q     <= 1'b0;
      adc_sweeping_q <= 1'b0;
      adc_port_q     <= '0;
      conv_ptr_q     <= '0;
      adc_start_q    <= 1'b0;
      adc_done_q     <= 1'b0;
    end else begin
      adc_start_q <= 1'b0;
      adc_done_q  <= 1'b0;
      if (adc_mode == ADC_IDLE || ports_hiz || adc_port_map == '0) begin
        adc_busy_q     <= 1'b0;
        adc_sweeping_q <= 1'b0;
        conv_ptr_q     <= '0;
      end else if (!adc_busy_q) begin
        if ((adc_mode == ADC_SINGLE_SWEEP && convert_trigger) ||
            adc_mode == ADC_CONT) begin
          adc_port_q     <= adc_first[PORT_W-1:0];
          adc_busy_q     <= 1'b1;
          adc_sweeping_q <= 1'b1;
          adc_start_q    <= 1'b1;
        end else if (adc_mode == ADC_SINGLE_CONV && convert_trigger) begin
          adc_port_q     <= adc_pick;
          conv_ptr_q     <= adc_pick + PORT_W'(1);
          adc_busy_q     <= 1'b1;
          adc_sweeping_q <= 1'b0;
          adc_start_q    <= 1'b1;
        end
      end else if (adc_conv_done) begin
        if (adc_sweeping_q && adc_port_q != PORT_W'(PORT_N - 1) &&
            adc_after[PORT_W]) begin
          adc_port_q  <= adc_after[PORT_W-1:0];
          adc_start_q <= 1'b1;
        end else begin
          adc_busy_q <= 1'b0;
          adc_done_q <= adc_sweeping_q;
        end
      end
    end
  end
  assign adc_start      = adc_start_q;
  assign adc_port       = adc_port_q;
  assign adc_sweep_done = adc_done_q;

  // Active-high request for the interrupt pin to pull low for 100 ns
  always_ff @(posedge clk) begin
    if (!rst_b || int_rst) pulse_cnt_q <= '0;
    else if (adc_done_q && adc_mode == ADC_CONT) pulse_cnt_q <= 3'(PULSE_CYC);
    else if (pulse_cnt_q != 3'h0) pulse_cnt_q <= pulse_cnt_q - 3'h1;
  end
  assign sweep_int_pulse = (pulse_cnt_q != 3'h0);

  // DAC update sequencer; an immediate request preempts the round robin
  always_ff @(posedge clk) begin
    if (!rst_b || int_rst) begin
      dac_port_q  <= '0;
      dac_busy_q  <= 1'b0;
      dac_start_q <= 1'b0;
      imm_pend_q  <= 1'b0;
      imm_port_q  <= '0;
      gap_cnt_q   <= '0;
    end else begin
      dac_start_q <= 1'b0;
      if (gap_cnt_q != 32'h0) gap_cnt_q <= gap_cnt_q - 32'h1;
      if (dac_mode != DAC_IMMEDIATE) imm_pend_q <= 1'b0;
      if (ports_hiz || dac_port_map == '0) begin
        dac_busy_q <= 1'b0;
      end else if (!dac_busy_q) begin
        // An early request waits out the gap while the round robin keeps going
        if (imm_pend_q && dac_mode == DAC_IMMEDIATE && gap_cnt_q == 32'h0) begin
          dac_port_q  <= imm_port_q;
          imm_pend_q  <= 1'b0;
          gap_cnt_q   <= IMM_GAP;
        end else begin
          dac_port_q  <= dac_pick;
        end
        dac_busy_q  <= 1'b1;
        dac_start_q <= 1'b1;
      end else if (dac_update_done) begin
        dac_busy_q <= 1'b0;
      end
      // Last, so a request landing as the pending one is taken is not lost
      if (dac_data_wr && dac_mode == DAC_IMMEDIATE && dac_port_map[dac_data_port]) begin
        imm_pend_q <= 1'b1;
        imm_port_q <= dac_data_port;
      end
    end
  end
  assign dac_update_start = dac_start_q;
  assign dac_port         = dac_port_q;
  assign dac_use_preset   = (dac_mode == DAC_PRESET1) || (dac_mode == DAC_PRESET2);
  assign dac_preset_value = (dac_mode == DAC_PRESET2) ? preset2_q : preset1_q;

  // Burst address stepping
  always_comb begin
    logic ctx;
    logic [PORT_W:0] nx;
    ctx = ctrl_q[BURST_BIT] &&
          ((burst_is_read && burst_adc_data) || (!burst_is_read && burst_dac_data));
    nx  = next_set(burst_is_read ? adc_port_map : dac_port_map, burst_port + PORT_W'(1));
    burst_next_port  = burst_port + PORT_W'(1);
    burst_next_valid = burst_step;
    if (ctx && burst_port != PORT_W'(PORT_N - 1)) begin
      burst_next_port  = nx[PORT_W-1:0];
      burst_next_valid = burst_step && nx[PORT_W];
    end else if (ctx) begin
      burst_next_valid = 1'b0;
    end
  end
endmodule : dcr_device_control

//--- verification/dcr_device_control_chk.sv
// Purpose: Port-level checks for the device control register.
// Assumes: One clock domain, synchronous active-low reset.
// Notes:   Sees only top-level ports; bound at the foot of this file.
`timescale 1ns/1ps
module dcr_device_control_chk
  import dcr_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        ctrl_wr,
  input wire logic [15:0] ctrl_wdata,
  input wire logic [15:0] ctrl_rdata,
  input wire logic [11:0] preset1_rdata,
  input wire logic [11:0] preset2_rdata,
  input wire logic        adc_start,
  input wire logic [1:0]  adc_rate_select,
  input wire logic        adc_sweep_done,
  input wire logic        sweep_int_pulse,
  input wire logic        dac_use_preset,
  input wire logic [11:0] dac_preset_value,
  input wire logic        dac_ref_select,
  input wire logic [2:0]  temp_monitor_enables,
  input wire logic        temp_conv_time_select,
  input wire logic        series_res_cancel_en,
  input wire logic        temp_int_valid,
  input wire logic [11:0] temp_int_value,
  input wire logic        low_power_en,
  input wire logic        ports_hiz,
  input wire logic        por_busy,
  input wire logic        device_reset,
  input wire logic        burst_step,
  input wire logic [4:0]  burst_port,
  input wire logic [4:0]  burst_next_port,
  input wire logic        burst_next_valid
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_idle;
    ctrl_rdata[1:0] == 2'h0 && $past(ctrl_rdata[1:0]) == 2'h0 |-> !adc_start;
  endproperty
  a_idle: assert property (p_idle) else $error("conversion started while idle");
  property p_rate;
    adc_rate_select == ctrl_rdata[5:4];
  endproperty
  a_rate: assert property (p_rate) else $error("rate select differs");
  property p_fields;
    {series_res_cancel_en, temp_conv_time_select, temp_monitor_enables, dac_ref_select}
      == {ctrl_rdata[12:8], ctrl_rdata[6]};
  endproperty
  a_fields: assert property (p_fields) else $error("field output differs");
  property p_lp;
    low_power_en == ctrl_rdata[13] && (!low_power_en || ports_hiz);
  endproperty
  a_lp: assert property (p_lp) else $error("low power ports not hiz");
  property p_lpexit;
    $fell(low_power_en) |-> ##[0:1] por_busy;
  endproperty
  a_lpexit: assert property (p_lpexit) else $error("no power-on after low power");
  property p_preset;
    ctrl_rdata[3] |-> dac_use_preset
      && dac_preset_value == (ctrl_rdata[2] ? preset2_rdata : preset1_rdata);
  endproperty
  a_preset: assert property (p_preset) else $error("preset value wrong");
  property p_therm;
    temp_int_valid && ctrl_rdata[7] && ctrl_rdata[8] && !temp_int_value[11]
      && temp_int_value > 12'h488 |-> device_reset ##1 ctrl_rdata == 16'h0000;
  endproperty
  a_therm: assert property (p_therm) else $error("no thermal reset");
  property p_soft;
    ctrl_wr && ctrl_wdata[15] |=> device_reset ##1 (ctrl_rdata == 16'h0000 && por_busy);
  endproperty
  a_soft: assert property (p_soft) else $error("soft reset missing");
  property p_rd15;
    ctrl_rdata[15] == 1'b0;
  endproperty
  a_rd15: assert property (p_rd15) else $error("reset bit reads one");
  property p_burst;
    burst_step && !ctrl_rdata[14] && burst_port < 5'h13
      |-> burst_next_valid && burst_next_port == burst_port + 5'h01;
  endproperty
  a_burst: assert property (p_burst) else $error("burst step not plus one");
  property p_pulse;
    ctrl_rdata[1:0] == 2'h3 && adc_sweep_done |=> sweep_int_pulse [*4];
  endproperty
  a_pulse: assert property (p_pulse) else $error("sweep pulse too short");
endmodule : dcr_device_control_chk
bind dcr_device_control dcr_device_control_chk i_chk (.*);

//--- verification/dcr_conv_model.sv
// Purpose: Converter and DAC engine answering start pulses.
// Assumes: Starts are pulses; one request outstanding per engine.
// Notes:   Slow mode stretches answers to exercise waiting logic.
`timescale 1ns/1ps
module dcr_conv_model (
  input  wire logic clk,
  input  wire logic slow,
  input  wire logic adc_start,
  input  wire logic dac_update_start,
  output logic      adc_conv_done,
  output logic      dac_update_done
);
  int a_cnt;
  int d_cnt;
  initial begin
    adc_conv_done = 1'b0;
    dac_update_done = 1'b0;
  end
  always @(posedge clk) begin
    adc_conv_done <= (a_cnt == 1);
    dac_update_done <= (d_cnt == 1);
    a_cnt <= adc_start ? (slow ? 6 : 1) : (a_cnt > 0 ? a_cnt - 1 : 0);
    d_cnt <= dac_update_start ? (slow ? 6 : 1) : (d_cnt > 0 ? d_cnt - 1 : 0);
  end
endmodule : dcr_conv_model

//--- verification/tb.sv
// Purpose: Self-checking bench for the device control register.
// Assumes: Converter model answers starts; host writes via strobes.
// Notes:   Fixed seed; DAC data writes exercise immediate update mode.
`timescale 1ns/1ps
module tb;
  import dcr_pkg::*;
  logic clk, rst_b, ctrl_wr, preset1_wr, preset2_wr, convert_trigger, adc_conv_done;
  logic adc_start, adc_sweep_done, sweep_int_pulse, dac_data_wr, dac_update_done, slow;
  logic dac_update_start, dac_use_preset, dac_ref_select, temp_conv_time_select;
  logic series_res_cancel_en, temp_int_valid, low_power_en, ports_hiz, por_busy;
  logic device_reset, burst_step, burst_is_read, burst_adc_data, burst_dac_data;
  logic burst_next_valid;
  logic [15:0] ctrl_wdata, ctrl_rdata, v;
  logic [11:0] preset_wdata, preset1_rdata, preset2_rdata, dac_preset_value, temp_int_value;
  logic [19:0] adc_port_map, dac_port_map;
  logic [4:0]  adc_port, dac_data_port, dac_port, burst_port, burst_next_port;
  logic [2:0]  temp_monitor_enables;
  logic [1:0]  adc_rate_select;
  logic [11:0] pv [2];
  logic [4:0]  q [$], dq [$];
  int          n_mismatch, comparisons, n_sweep, cyc, e, k;
  dcr_device_control #(.IMM_GAP(4)) i_dut (.*);
  dcr_conv_model i_far (.*);
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (adc_start) q.push_back(adc_port);
    if (dac_update_start) dq.push_back(dac_port);
    if (adc_sweep_done) n_sweep++;
    if (cyc > 20000) begin
      n_mismatch++;
      test_done();
    end
  end
  task automatic chk(logic [63:0] got, logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  task automatic run(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : run
  task automatic wr(logic [15:0] d);
    @(posedge clk);
    ctrl_wr <= 1'b1;
    ctrl_wdata <= d;
    @(posedge clk);
    ctrl_wr <= 1'b0;
    #1;
  endtask : wr
  task automatic trig();
    @(posedge clk);
    convert_trigger <= 1'b1;
    @(posedge clk);
    convert_trigger <= 1'b0;
  endtask : trig
  function automatic int nxt(logic [19:0] m, int p);
    for (int i = p + 1; i < 20; i++)
      if (m[i]) return i;
    return -1;
  endfunction : nxt
  function automatic int nxw(logic [19:0] m, int p);
    return (nxt(m, p) < 0) ? nxt(m, -1) : nxt(m, p);
  endfunction : nxw
  task automatic test_done();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  initial begin
    {rst_b, ctrl_wr, preset1_wr, preset2_wr, convert_trigger, dac_data_wr, slow} = '0;
    {temp_int_valid, burst_step, burst_is_read, burst_adc_data, burst_dac_data} = '0;
    {ctrl_wdata, preset_wdata, temp_int_value, dac_data_port, burst_port} = '0;
    v = 16'($urandom(32'haf69906f));
    // Port 0 is always ADC and port 19 always DAC, so neither map is empty
    adc_port_map = (20'($urandom) & 20'h7FFFF) | 20'h00001;
    dac_port_map = ~adc_port_map;
    run(20);
    rst_b <= 1'b1;
    run(20);
    chk({ctrl_rdata, preset1_rdata, preset2_rdata}, 40'h0);
    for (int i = 0; i < 8; i++) begin
      v = (16'($urandom) & 16'h5FCC) | 16'(i << 4);
      wr(v);
      chk(ctrl_rdata, v);
      chk({adc_rate_select, dac_ref_select, temp_monitor_enables}, {2'(i), v[6], v[10:8]});
    end
    // Presets captured before any preset mode, so a stale mux would show
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      pv[i] = 12'($urandom);
      preset_wdata <= pv[i];
      {preset1_wr, preset2_wr} <= (i == 0) ? 2'b10 : 2'b01;
    end
    @(posedge clk);
    {preset1_wr, preset2_wr} <= 2'b00;
    for (int m = 2; m < 4; m++) begin
      wr(16'(m << 2));
      chk({dac_use_preset, dac_preset_value}, {1'b1, pv[m - 2]});
    end
    slow <= 1'b1;
    n_sweep = 0;
    q.delete();
    wr(16'h0001);
    trig();
    for (int k = 0; k < 400 && n_sweep == 0; k++) @(posedge clk);
    run(30);
    e = nxt(adc_port_map, -1);
    foreach (q[j]) begin
      chk(q[j], e);
      e = nxt(adc_port_map, e);
    end
    chk(q.size(), $countones(adc_port_map));
    wr(16'h0002);
    e = -1;
    repeat ($countones(adc_port_map) + 1) begin
      q.delete();
      slow <= ~slow;
      trig();
      run(12);
      e = nxw(adc_port_map, e);
      chk({q.size(), q[0]}, {32'h1, 5'(e)});
    end
    n_sweep = 0;
    wr(16'h0003);
    trig();
    for (int k = 0; k < 900 && n_sweep < 2; k++) @(posedge clk);
    chk(n_sweep >= 2, 1);
    wr(16'h0000);
    run(20);
    q.delete();
    trig();
    run(20);
    chk(q.size(), 0);
    dq.delete();
    run(60);
    chk(dq.size() > 3, 1);
    foreach (dq[j]) begin
      if (j > 0) chk(dq[j], nxw(dac_port_map, dq[j - 1]));
    end
    // One round-robin update may already be under way when the request lands
    wr(16'h0004);
    for (int r = 0; r < 2; r++) begin
      e = nxw(dac_port_map, int'($urandom % 20));
      @(posedge clk);
      dac_data_wr <= 1'b1;
      dac_data_port <= 5'(e);
      @(posedge clk);
      dac_data_wr <= 1'b0;
      dq.delete();
      run(40);
      k = (dq[0] == 5'(e) && dq[1] != 5'(e)) ? 0 : 1;
      chk({dq[k], dq[k + 1]}, {5'(e), 5'(nxw(dac_port_map, e))});
      run(IMM_GAP_CYC);
    end
    for (int i = 0; i < 6; i++) begin
      wr((i < 3) ? 16'h0000 : 16'h4000);
      @(posedge clk);
      burst_port <= 5'($urandom % 19);
      {burst_step, burst_is_read, burst_adc_data, burst_dac_data} <= {2'b11, i != 5, i == 5};
      #1;
      e = (i < 3 || i == 5) ? int'(burst_port) + 1 : nxt(adc_port_map, int'(burst_port));
      if (e < 0) chk(burst_next_valid, 0);
      else chk({burst_next_valid, burst_next_port}, {1'b1, 5'(e)});
    end
    burst_step <= 1'b0;
    wr(16'h2000);
    chk(ports_hiz, 1);
    wr(16'h0000);
    run(1);
    chk(por_busy, 1);
    run(20);
    for (int i = 0; i < 2; i++) begin
      wr(16'h0180);
      @(posedge clk);
      temp_int_valid <= 1'b1;
      temp_int_value <= 12'h488 + 12'(i);
      @(posedge clk);
      temp_int_valid <= 1'b0;
      run(1);
      chk(ctrl_rdata, i ? 16'h0000 : 16'h0180);
      run(20);
    end
    @(posedge clk);
    preset1_wr <= 1'b1;
    preset_wdata <= 12'hA5C;
    @(posedge clk);
    preset1_wr <= 1'b0;
    wr(16'h9F70);
    run(1);
    chk({ctrl_rdata, por_busy, preset1_rdata}, {16'h0000, 1'b1, 12'h000});
    test_done();
  end
endmodule : tb
